// ---- inc/qui_pkg.sv ----
// Constants shared by the four-channel interrupt status block.
//
// Function
// - One active-low open-drain request, raised by any enabled event.
// - Two each of status, mask, masked-status and vector registers.
// - Offsets 05/15 read status; writes there load write-only masks.
// - Masked status read-only at 02 and 12; vectors at 0C and 1C.
// - Status AB 7..0: input, brkB, rxB, txB, ctr1, brkA, rxA, txA.
// - Status CD mirrors AB; bit 3 counter 2, bit 7 pins 8-11, bit 6 brkD.
// - AB bit 7 sets on enabled pin 0-3 change; low capture read clears.
// - CD bit 7 sets on enabled pin 8-11 change; high capture read clears.
// - Break bit sets on break start or end; reset command clears.
// - Channel D break bit, CD bit 6, likewise with its own command.
// - Receive bit is ready or FIFO-full, chosen by mode bit 6.
// - Ready mode: set on load, clear on pop, set again if not empty.
// - Full mode: set when a load fills the FIFO, clear on pop.
// - Full mode stays quiet with one to three characters held.
// - Transmit-ready bit copies channel status bit 2.
// - Transmit-ready clears on holding write, sets on move to shifter.
// - Transmit-ready sets on enable, clears on disable; disabled writes dropped.
// - Counter mode: ready sets at terminal count; stop clears and halts.
// - Timer mode: ready sets each wave cycle; stop clears, timer runs on.
// - Masked status is status AND mask, bit by bit.
// - Mask bit 1 enables, 0 masks; masks not readable.
`default_nettype none

package qui_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int QUI_CHANNELS = 4;
   localparam int QUI_COUNTERS = 2;
   localparam logic [2:0] QUI_RX_DEPTH = 3'h4;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [4:0] QUI_OFF_MASKED_AB = 5'h02;
   localparam logic [4:0] QUI_OFF_STATUS_AB = 5'h05;
   localparam logic [4:0] QUI_OFF_VECTOR_AB = 5'h0c;
   localparam logic [4:0] QUI_OFF_MASKED_CD = 5'h12;
   localparam logic [4:0] QUI_OFF_STATUS_CD = 5'h15;
   localparam logic [4:0] QUI_OFF_VECTOR_CD = 5'h1c;
   // ----------------------------------------
   // Status bit positions, same in both registers
   // ----------------------------------------
   localparam int QUI_BIT_TX_LO = 0;
   localparam int QUI_BIT_RX_LO = 1;
   localparam int QUI_BIT_BRK_LO = 2;
   localparam int QUI_BIT_CTR = 3;
   localparam int QUI_BIT_TX_HI = 4;
   localparam int QUI_BIT_RX_HI = 5;
   localparam int QUI_BIT_BRK_HI = 6;
   localparam int QUI_BIT_INPUT = 7;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] QUI_MASK_RESET = 8'h00;
   localparam logic [7:0] QUI_VECTOR_RESET = 8'h00;
   localparam logic [7:0] QUI_READ_IDLE = 8'h00;
endpackage : qui_pkg

`default_nettype wire

// ---- inc/qui_chan_if.sv ----
// Per-channel event and status bundle between the top and a channel slice.
`default_nettype none

interface qui_chan_if;
   logic rx_full_mode;
   logic rx_load;
   logic rx_pop;
   logic tx_enable_cmd;
   logic tx_disable_cmd;
   logic tx_hold_write;
   logic tx_to_shift;
   logic break_edge;
   logic break_clear;
   logic rx_bit;
   logic tx_bit;
   logic break_bit;
   logic tx_write_taken;
   modport ctl (
      output rx_full_mode, rx_load, rx_pop, tx_enable_cmd, tx_disable_cmd,
      output tx_hold_write, tx_to_shift, break_edge, break_clear,
      input rx_bit, tx_bit, break_bit, tx_write_taken
   );
   modport chan (
      input rx_full_mode, rx_load, rx_pop, tx_enable_cmd, tx_disable_cmd,
      input tx_hold_write, tx_to_shift, break_edge, break_clear,
      output rx_bit, tx_bit, break_bit, tx_write_taken
   );
endinterface : qui_chan_if

`default_nettype wire

// ---- rtl/qui_chan_status.sv ----
// One channel's receive, transmit-ready and break-change status bits.
`default_nettype none

module qui_chan_status
   import qui_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Channel bundle
   qui_chan_if.chan bus
);
   logic [2:0] rx_count;
   logic [2:0] next_rx_count;
   logic load_ok;
   logic pop_ok;
   logic tx_enabled;

   // Occupancy of the holding FIFO; a load into a full FIFO waits upstream
   assign load_ok = bus.rx_load && ((rx_count != QUI_RX_DEPTH) || bus.rx_pop);
   assign pop_ok = bus.rx_pop && (rx_count != 3'h0);
   assign next_rx_count = 3'(rx_count + {2'h0, load_ok} - {2'h0, pop_ok});
   assign bus.tx_write_taken = bus.tx_hold_write && tx_enabled;

   always_ff @(posedge clk) begin
      if (srst) rx_count <= 3'h0;
      else rx_count <= next_rx_count;
   end

   // Receive bit; a load in the pop cycle wins so no character goes unflagged
   always_ff @(posedge clk) begin
      if (srst) begin
         bus.rx_bit <= 1'b0;
      end else if (load_ok && (!bus.rx_full_mode || next_rx_count == QUI_RX_DEPTH)) begin
         bus.rx_bit <= 1'b1;
      end else if (pop_ok) begin
         bus.rx_bit <= 1'b0;
      end else if (!bus.rx_full_mode && rx_count != 3'h0) begin
         bus.rx_bit <= 1'b1;
      end
   end

   // Transmitter enable and holding-register empty flag
   always_ff @(posedge clk) begin
      if (srst) begin
         tx_enabled <= 1'b0;
         bus.tx_bit <= 1'b0;
      end else if (bus.tx_disable_cmd) begin
         tx_enabled <= 1'b0;
         bus.tx_bit <= 1'b0;
      end else if (bus.tx_enable_cmd && !tx_enabled) begin
         tx_enabled <= 1'b1;
         bus.tx_bit <= 1'b1;
      end else if (tx_enabled && bus.tx_to_shift) begin
         bus.tx_bit <= 1'b1;
      end else if (bus.tx_write_taken) begin
         bus.tx_bit <= 1'b0;
      end
   end

   // Break change is sticky; an edge in the clear cycle wins
   always_ff @(posedge clk) begin
      if (srst) bus.break_bit <= 1'b0;
      else if (bus.break_edge) bus.break_bit <= 1'b1;
      else if (bus.break_clear) bus.break_bit <= 1'b0;
   end
endmodule : qui_chan_status

`default_nettype wire

// ---- rtl/qui_ctr_status.sv ----
// Counter/timer ready flag and run state for one counter/timer.
`default_nettype none

module qui_ctr_status
   import qui_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Counter events
   input wire logic timer_mode,
   input wire logic start_cmd,
   input wire logic stop_cmd,
   input wire logic terminal_count,
   input wire logic wave_cycle,
   // Status
   output logic ready,
   output logic running
);
   // Ready flag; a new event in the stop cycle is kept
   always_ff @(posedge clk) begin
      if (srst) ready <= 1'b0;
      else if (timer_mode ? wave_cycle : terminal_count) ready <= 1'b1;
      else if (stop_cmd) ready <= 1'b0;
   end

   // Stop halts only a counter; a timer keeps generating its wave
   always_ff @(posedge clk) begin
      if (srst) running <= 1'b0;
      else if (start_cmd) running <= 1'b1;
      else if (stop_cmd && !timer_mode) running <= 1'b0;
   end
endmodule : qui_ctr_status

`default_nettype wire

// ---- rtl/qui_top.sv ----
// Interrupt status, mask, masked-status and vector registers.
`default_nettype none

module qui_top
   import qui_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Host register port
   input wire logic [4:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   // Open-drain interrupt request pin
   output logic irq_request_n_out,
   output logic irq_request_n_oe_n,
   // Receiver events, one bit per channel A..D
   input wire logic [3:0] rx_full_mode,
   input wire logic [3:0] rx_load,
   input wire logic [3:0] rx_pop,
   // Transmitter events
   input wire logic [3:0] tx_enable_cmd,
   input wire logic [3:0] tx_disable_cmd,
   input wire logic [3:0] tx_hold_write,
   input wire logic [3:0] tx_to_shift,
   // Break events and reset-break-change commands
   input wire logic [3:0] break_edge,
   input wire logic [3:0] break_change_clear,
   // Channel status copies
   output logic [3:0] tx_hold_empty,
   output logic [3:0] tx_write_taken,
   // Counter/timer 1 and 2
   input wire logic [1:0] ctr_timer_mode,
   input wire logic [1:0] ctr_start_cmd,
   input wire logic [1:0] ctr_stop_cmd,
   input wire logic [1:0] ctr_terminal,
   input wire logic [1:0] timer_wave_cycle,
   output logic [1:0] ctr_running,
   // Input port pins 0-3 in bits 3:0, pins 8-11 in bits 7:4
   input wire logic [7:0] ip_pin,
   input wire logic [3:0] aux_control_low,
   input wire logic [3:0] aux_control_high,
   input wire logic input_change_capture_low_read,
   input wire logic input_change_capture_high_read
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0] irq_enable_ab;
   logic [7:0] irq_enable_cd;
   logic [7:0] irq_vector_ab;
   logic [7:0] irq_vector_cd;
   logic [7:0] irq_status_ab;
   logic [7:0] irq_status_cd;
   logic [7:0] masked_irq_status_ab;
   logic [7:0] masked_irq_status_cd;
   logic [7:0] next_rdata;
   logic [3:0] rx_bit;
   logic [3:0] tx_bit;
   logic [3:0] break_bit;
   logic [1:0] ctr_ready;
   logic [7:0] ip_meta;
   logic [7:0] ip_sync;
   logic [7:0] ip_prev;
   logic ip_primed;
   logic [7:0] ip_delta;
   logic input_change_low;
   logic input_change_high;
   logic wr_status_ab;
   logic wr_status_cd;
   logic wr_vector_ab;
   logic wr_vector_cd;

   // ----------------------------------------
   // Channel slices
   // ----------------------------------------
   qui_chan_if chan_bus [QUI_CHANNELS] ();

   // One slice per channel
   generate
      for (genvar g = 0; g < QUI_CHANNELS; g++) begin : g_chan
         assign chan_bus[g].rx_full_mode = rx_full_mode[g];
         assign chan_bus[g].rx_load = rx_load[g];
         assign chan_bus[g].rx_pop = rx_pop[g];
         assign chan_bus[g].tx_enable_cmd = tx_enable_cmd[g];
         assign chan_bus[g].tx_disable_cmd = tx_disable_cmd[g];
         assign chan_bus[g].tx_hold_write = tx_hold_write[g];
         assign chan_bus[g].tx_to_shift = tx_to_shift[g];
         assign chan_bus[g].break_edge = break_edge[g];
         assign chan_bus[g].break_clear = break_change_clear[g];
         assign rx_bit[g] = chan_bus[g].rx_bit;
         assign tx_bit[g] = chan_bus[g].tx_bit;
         assign break_bit[g] = chan_bus[g].break_bit;
         assign tx_write_taken[g] = chan_bus[g].tx_write_taken;

         qui_chan_status u_chan (
            .clk (clk),
            .srst (srst),
            .bus (chan_bus[g].chan)
         );
      end
   endgenerate

   // Channel status bit 2 and the interrupt bit are one flop
   assign tx_hold_empty = tx_bit;

   // ----------------------------------------
   // Counter/timer slices
   // ----------------------------------------
   generate
      for (genvar c = 0; c < QUI_COUNTERS; c++) begin : g_ctr
         qui_ctr_status u_ctr (
            .clk (clk),
            .srst (srst),
            .timer_mode (ctr_timer_mode[c]),
            .start_cmd (ctr_start_cmd[c]),
            .stop_cmd (ctr_stop_cmd[c]),
            .terminal_count (ctr_terminal[c]),
            .wave_cycle (timer_wave_cycle[c]),
            .ready (ctr_ready[c]),
            .running (ctr_running[c])
         );
      end
   endgenerate

   // ----------------------------------------
   // Input port change detection
   // ----------------------------------------
   // Pins are asynchronous; two flops before anything looks at them
   always_ff @(posedge clk) begin
      if (srst) begin
         ip_meta <= 8'h00;
         ip_sync <= 8'h00;
      end else begin
         ip_meta <= ip_pin;
         ip_sync <= ip_meta;
      end
   end

   // Previous sample; only the first cycle after reset is masked, so a pin high out of reset counts as a change
   always_ff @(posedge clk) begin
      if (srst) begin
         ip_prev <= 8'h00;
         ip_primed <= 1'b0;
      end else begin
         ip_prev <= ip_sync;
         ip_primed <= 1'b1;
      end
   end

   // Only pins selected in the aux control nibbles count
   assign ip_delta = (ip_sync ^ ip_prev) & {aux_control_high, aux_control_low}
                     & {8{ip_primed}};

   // Sticky change flags; a change in the capture-read cycle is kept
   always_ff @(posedge clk) begin
      if (srst) input_change_low <= 1'b0;
      else if (|ip_delta[3:0]) input_change_low <= 1'b1;
      else if (input_change_capture_low_read) input_change_low <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (srst) input_change_high <= 1'b0;
      else if (|ip_delta[7:4]) input_change_high <= 1'b1;
      else if (input_change_capture_high_read) input_change_high <= 1'b0;
   end

   // ----------------------------------------
   // Status assembly
   // ----------------------------------------
   // Both registers share one layout
   always_comb begin
      irq_status_ab = 8'h00;
      irq_status_ab[QUI_BIT_TX_LO] = tx_bit[0];
      irq_status_ab[QUI_BIT_RX_LO] = rx_bit[0];
      irq_status_ab[QUI_BIT_BRK_LO] = break_bit[0];
      irq_status_ab[QUI_BIT_CTR] = ctr_ready[0];
      irq_status_ab[QUI_BIT_TX_HI] = tx_bit[1];
      irq_status_ab[QUI_BIT_RX_HI] = rx_bit[1];
      irq_status_ab[QUI_BIT_BRK_HI] = break_bit[1];
      irq_status_ab[QUI_BIT_INPUT] = input_change_low;
   end

   always_comb begin
      irq_status_cd = 8'h00;
      irq_status_cd[QUI_BIT_TX_LO] = tx_bit[2];
      irq_status_cd[QUI_BIT_RX_LO] = rx_bit[2];
      irq_status_cd[QUI_BIT_BRK_LO] = break_bit[2];
      irq_status_cd[QUI_BIT_CTR] = ctr_ready[1];
      irq_status_cd[QUI_BIT_TX_HI] = tx_bit[3];
      irq_status_cd[QUI_BIT_RX_HI] = rx_bit[3];
      irq_status_cd[QUI_BIT_BRK_HI] = break_bit[3];
      irq_status_cd[QUI_BIT_INPUT] = input_change_high;
   end

   // Status bits rise whatever the mask says; the masked views spare software the AND
   assign masked_irq_status_ab = irq_status_ab & irq_enable_ab;
   assign masked_irq_status_cd = irq_status_cd & irq_enable_cd;

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   assign wr_status_ab = bus_wr && (bus_addr == QUI_OFF_STATUS_AB);
   assign wr_status_cd = bus_wr && (bus_addr == QUI_OFF_STATUS_CD);
   assign wr_vector_ab = bus_wr && (bus_addr == QUI_OFF_VECTOR_AB);
   assign wr_vector_cd = bus_wr && (bus_addr == QUI_OFF_VECTOR_CD);

   // Masks are write-only; a write at the status offset lands here
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_enable_ab <= QUI_MASK_RESET;
         irq_enable_cd <= QUI_MASK_RESET;
      end else begin
         if (wr_status_ab) irq_enable_ab <= bus_wdata;
         if (wr_status_cd) irq_enable_cd <= bus_wdata;
      end
   end

   // Vectors are not driven out on acknowledge here, so they are plain storage
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_vector_ab <= QUI_VECTOR_RESET;
         irq_vector_cd <= QUI_VECTOR_RESET;
      end else begin
         if (wr_vector_ab) irq_vector_ab <= bus_wdata;
         if (wr_vector_cd) irq_vector_cd <= bus_wdata;
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   // Read decode; unmapped offsets read zero
   always_comb begin
      case (bus_addr)
         QUI_OFF_MASKED_AB: next_rdata = masked_irq_status_ab;
         QUI_OFF_STATUS_AB: next_rdata = irq_status_ab;
         QUI_OFF_VECTOR_AB: next_rdata = irq_vector_ab;
         QUI_OFF_MASKED_CD: next_rdata = masked_irq_status_cd;
         QUI_OFF_STATUS_CD: next_rdata = irq_status_cd;
         QUI_OFF_VECTOR_CD: next_rdata = irq_vector_cd;
         default: next_rdata = QUI_READ_IDLE;
      endcase
   end

   // Read data holds until the next read
   always_ff @(posedge clk) begin
      if (srst) bus_rdata <= QUI_READ_IDLE;
      else if (bus_rd) bus_rdata <= next_rdata;
   end

   // ----------------------------------------
   // Interrupt request pin
   // ----------------------------------------
   // Open drain: data always low, only the enable moves
   assign irq_request_n_out = 1'b0;

   // Registered so the pin never glitches while status bits settle
   always_ff @(posedge clk) begin
      if (srst) irq_request_n_oe_n <= 1'b1;
      else irq_request_n_oe_n <= ~(|masked_irq_status_ab | |masked_irq_status_cd);
   end
endmodule : qui_top

`default_nettype wire

// ---- verification/qui_monitor.sv ----
// Port checker for the interrupt status block, bound to its top module.
`default_nettype none

module qui_monitor
   import qui_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Host register port and request pin
   input wire logic [4:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   input wire logic irq_request_n_out,
   input wire logic irq_request_n_oe_n,
   // Channel and counter events
   input wire logic [3:0] break_edge,
   input wire logic [3:0] tx_enable_cmd,
   input wire logic [3:0] tx_disable_cmd,
   input wire logic [3:0] tx_to_shift,
   input wire logic [3:0] tx_hold_empty,
   input wire logic [3:0] tx_write_taken,
   input wire logic [1:0] ctr_timer_mode,
   input wire logic [1:0] ctr_start_cmd,
   input wire logic [1:0] ctr_stop_cmd,
   input wire logic [1:0] ctr_running
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic [7:0] mask_ab;
   logic [7:0] mask_cd;
   // ----------------------------------------
   // Mask shadows
   // ----------------------------------------
   // Masks are write-only; rebuild them from bus writes
   always_ff @(posedge clk) begin
      if (srst) begin
         mask_ab <= QUI_MASK_RESET;
         mask_cd <= QUI_MASK_RESET;
      end else if (bus_wr && bus_addr == QUI_OFF_STATUS_AB) begin
         mask_ab <= bus_wdata;
      end else if (bus_wr && bus_addr == QUI_OFF_STATUS_CD) begin
         mask_cd <= bus_wdata;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_reset_idle: assert property ($fell(srst) |-> bus_rdata == 8'h00 && irq_request_n_oe_n)
      else $error("not idle after reset");
   a_pin_data_low: assert property (irq_request_n_out == 1'b0)
      else $error("open-drain data not low");
   a_break_to_irq: assert property (break_edge[0] && mask_ab[2] && !bus_wr |-> ##2 !irq_request_n_oe_n)
      else $error("break did not raise request");
   a_no_mask_quiet: assert property ((mask_ab == 8'h00 && mask_cd == 8'h00)[*2] |-> irq_request_n_oe_n)
      else $error("request while all masked");
   a_tx_disable_clr: assert property (tx_disable_cmd[0] && !tx_enable_cmd[0] && !tx_to_shift[0] |=> !tx_hold_empty[0])
      else $error("tx ready set after disable");
   a_tx_write_clr: assert property (tx_write_taken[0] && !tx_to_shift[0] && !tx_enable_cmd[0] && !tx_disable_cmd[0] |=> !tx_hold_empty[0])
      else $error("tx ready set after write");
   a_tx_shift_set: assert property (tx_to_shift[0] && !tx_disable_cmd[0] |=> tx_hold_empty[0])
      else $error("tx ready not set after shift");
   a_disabled_drop: assert property ((tx_disable_cmd[1] && !tx_enable_cmd[1]) ##1 !tx_enable_cmd[1] |-> !tx_write_taken[1])
      else $error("write taken while disabled");
   a_counter_halts: assert property (!ctr_timer_mode[0] && ctr_stop_cmd[0] && !ctr_start_cmd[0] |=> !ctr_running[0])
      else $error("counter still running after stop");
   a_timer_keeps: assert property (ctr_timer_mode[1] && ctr_running[1] && ctr_stop_cmd[1] && !ctr_start_cmd[1] |=> ctr_running[1])
      else $error("timer halted by stop");
   a_rdata_holds: assert property (!bus_rd |=> $stable(bus_rdata))
      else $error("read data changed without a read");
   // Main scenarios reached
   c_irq_active: cover property (!irq_request_n_oe_n);
   c_masked_read: cover property (bus_rd && bus_addr == QUI_OFF_MASKED_CD);
   c_timer_stop: cover property (ctr_timer_mode[1] && ctr_stop_cmd[1]);
endmodule : qui_monitor

bind qui_top qui_monitor u_mon (.*);

`default_nettype wire

// ---- verification/qui_host.sv ----
// Host processor model driving the register port.
`default_nettype none

module qui_host
   import qui_pkg::*;
(
   // Clock
   input wire logic clk,
   // Register port
   output logic [4:0] bus_addr,
   output logic bus_rd,
   output logic bus_wr,
   output logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle bus; address and data never keep the last value
   initial begin
      bus_addr = 5'h1f;
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      bus_wdata = 8'h00;
   end
   // One write, strobe up for one edge
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(posedge clk);
      #1;
      bus_wr = 1'b0;
      bus_addr = ~a;
      bus_wdata = ~d;
   endtask : wr
   // One read; data taken after the sampling edge
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      bus_addr = a;
      bus_rd = 1'b1;
      @(posedge clk);
      #1;
      d = bus_rdata;
      bus_rd = 1'b0;
      bus_addr = ~a;
   endtask : rd
endmodule : qui_host

`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the interrupt status block.
`default_nettype none

module tb
   import qui_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [4:0] SAB = QUI_OFF_STATUS_AB;
   localparam logic [4:0] SCD = QUI_OFF_STATUS_CD;
   logic clk, srst, bus_rd, bus_wr, irq_request_n_out, irq_request_n_oe_n;
   logic [4:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata, ip_pin, d, m1, m2, s1, s2;
   logic [3:0] rx_full_mode, rx_load, rx_pop, tx_enable_cmd, tx_disable_cmd, tx_hold_write;
   logic [3:0] tx_to_shift, break_edge, break_change_clear, tx_hold_empty, tx_write_taken;
   logic [3:0] aux_control_low, aux_control_high, b;
   logic [1:0] ctr_timer_mode, ctr_start_cmd, ctr_stop_cmd, ctr_terminal, timer_wave_cycle;
   logic [1:0] ctr_running;
   logic input_change_capture_low_read, input_change_capture_high_read;
   int num_errors = 0;
   int n_compared = 0;
   integer seed = 32'h6cfbc506;
   qui_top DUT (.*);
   qui_host host (.clk, .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata);
   // ----------------------------------------
   // Helpers and expectations
   // ----------------------------------------
   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk8
   task automatic chk1(input string n, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask : chk1
   task automatic rchk(input logic [4:0] a, input logic [7:0] e);
      logic [7:0] v;
      host.rd(a, v);
      chk8($sformatf("register %h", a), e, v);
   endtask : rchk
   // One-cycle event pulse
   task automatic pulse4(ref logic [3:0] s, input logic [3:0] v);
      tick;
      s = v;
      tick;
      s = 4'h0;
   endtask : pulse4
   function automatic logic [7:0] brk_bits(input logic lo, input logic hi);
      return {1'b0, hi, 3'b000, lo, 2'b00};
   endfunction : brk_bits
   function automatic logic irq_n(input logic [7:0] a, input logic [7:0] b);
      return ~|(a | b);
   endfunction : irq_n
   task automatic close_out;
      $display("mismatches %0d comparisons %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out
   // Clock and watchdog; the run needs well under a thousand cycles
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #100000;
      num_errors++;
      close_out;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      srst = 1'b1;
      {rx_load, rx_pop, tx_enable_cmd, tx_disable_cmd, tx_hold_write, tx_to_shift} = '0;
      {break_edge, break_change_clear, ctr_start_cmd, ctr_stop_cmd, ctr_terminal} = '0;
      {timer_wave_cycle, ip_pin, input_change_capture_low_read} = '0;
      input_change_capture_high_read = 1'b0;
      rx_full_mode = 4'b0010;
      ctr_timer_mode = 2'b10;
      aux_control_low = 4'h1;
      aux_control_high = 4'h1;
      repeat (16) @(posedge clk);
      #1;
      srst = 1'b0;
      for (int i = 0; i < 8; i++) begin
         rchk(5'({i[2:0], 2'b00} ^ 5'h02), QUI_READ_IDLE);
      end
      host.wr(SAB, 8'hff);
      rchk(SAB, 8'h00);
      for (int i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         host.wr(i[0] ? QUI_OFF_VECTOR_CD : QUI_OFF_VECTOR_AB, d);
         rchk(i[0] ? QUI_OFF_VECTOR_CD : QUI_OFF_VECTOR_AB, d);
      end
      // Break changes on all channels, then cleared one at a time
      host.wr(SAB, 8'h44);
      host.wr(SCD, 8'h00);
      pulse4(break_edge, 4'hf);
      rchk(SAB, 8'h44);
      rchk(SCD, 8'h44);
      chk1("request", 1'b0, irq_request_n_oe_n);
      b = 4'hf;
      for (int ch = 0; ch < 4; ch++) begin
         pulse4(break_change_clear, 4'(1 << ch));
         b[ch] = 1'b0;
         rchk(SAB, brk_bits(b[0], b[1]));
         rchk(SCD, brk_bits(b[2], b[3]));
      end
      chk1("request", 1'b1, irq_request_n_oe_n);
      // Receive ready on A with two loads, FIFO full on B
      host.wr(SAB, 8'h02);
      tick;
      rx_load = 4'h1;
      repeat (2) tick;
      rx_load = 4'h0;
      rchk(SAB, 8'h02);
      pulse4(rx_pop, 4'h1);
      tick;
      chk1("request", 1'b1, irq_request_n_oe_n);
      tick;
      chk1("request", 1'b0, irq_request_n_oe_n);
      pulse4(rx_pop, 4'h1);
      rchk(SAB, 8'h00);
      tick;
      rx_load = 4'h2;
      repeat (3) tick;
      rx_load = 4'h0;
      rchk(SAB, 8'h00);
      pulse4(rx_load, 4'h2);
      rchk(SAB, 8'h20);
      pulse4(rx_pop, 4'h2);
      rchk(SAB, 8'h00);
      pulse4(rx_load, 4'h2);
      rchk(SAB, 8'h20);
      pulse4(rx_pop, 4'h2);
      // Transmit ready: enable, write, transfer, disable
      pulse4(tx_enable_cmd, 4'hf);
      chk8("tx_hold_empty", 8'h0f, {4'h0, tx_hold_empty});
      rchk(SCD, 8'h11);
      tick;
      tx_hold_write = 4'h5;
      #1;
      chk8("tx_write_taken", 8'h05, {4'h0, tx_write_taken});
      tick;
      tx_hold_write = 4'h0;
      chk8("tx_hold_empty", 8'h0a, {4'h0, tx_hold_empty});
      rchk(SAB, 8'h10);
      pulse4(tx_to_shift, 4'h5);
      chk8("tx_hold_empty", 8'h0f, {4'h0, tx_hold_empty});
      pulse4(tx_disable_cmd, 4'h2);
      tx_hold_write = 4'h2;
      #1;
      chk8("tx_write_taken", 8'h00, {4'h0, tx_write_taken});
      tick;
      tx_hold_write = 4'h0;
      chk8("tx_hold_empty", 8'h0d, {4'h0, tx_hold_empty});
      // Counter 1 in counter mode, counter 2 in timer mode
      tick;
      ctr_start_cmd = 2'b11;
      tick;
      ctr_start_cmd = 2'b00;
      ctr_terminal = 2'b01;
      timer_wave_cycle = 2'b10;
      tick;
      {ctr_terminal, timer_wave_cycle} = '0;
      rchk(SAB, 8'h09);
      rchk(SCD, 8'h19);
      ctr_stop_cmd = 2'b11;
      tick;
      ctr_stop_cmd = 2'b00;
      chk8("ctr_running", 8'h02, {6'h00, ctr_running});
      rchk(SAB, 8'h01);
      rchk(SCD, 8'h11);
      // Input change: pin 0 and pin 8 selected, pin 9 not
      host.wr(SAB, 8'h80);
      ip_pin = 8'h21;
      repeat (6) tick;
      rchk(SAB, 8'h81);
      rchk(SCD, 8'h11);
      chk1("request", 1'b0, irq_request_n_oe_n);
      ip_pin = 8'h31;
      repeat (6) tick;
      rchk(SCD, 8'h91);
      {input_change_capture_low_read, input_change_capture_high_read} = 2'b11;
      tick;
      {input_change_capture_low_read, input_change_capture_high_read} = 2'b00;
      rchk(SAB, 8'h01);
      rchk(SCD, 8'h11);
      // Random breaks and masks; masked views and the pin follow
      for (int i = 0; i < 8; i++) begin
         b = 4'($random(seed));
         pulse4(break_edge, b);
         m1 = 8'($random(seed));
         m2 = 8'($random(seed));
         host.wr(SAB, m1);
         host.wr(SCD, m2);
         host.wr(QUI_OFF_MASKED_CD, ~m2);
         s1 = 8'h01 | brk_bits(b[0], b[1]);
         s2 = 8'h11 | brk_bits(b[2], b[3]);
         rchk(SAB, s1);
         rchk(QUI_OFF_MASKED_AB, s1 & m1);
         rchk(QUI_OFF_MASKED_CD, s2 & m2);
         chk1("request", irq_n(s1 & m1, s2 & m2), irq_request_n_oe_n);
         pulse4(break_change_clear, 4'hf);
      end
      close_out;
   end
endmodule : tb

`default_nettype wire
